// >>> hw/pin_select_pkg.sv
`default_nettype none

package pin_select_pkg;

	// ----------------------------------------------------------------
	// Bus and map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int NUM_GROUPS = 5;
	localparam logic [ADDR_W-1:0] ADDR_COMPAT = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_6 = 12'h018;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_7 = 12'h01C;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_8 = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_9 = 12'h024;
	localparam logic [ADDR_W-1:0] ADDR_GROUP_A = 12'h028;

	// Slot codes returned by the address decoder
	localparam logic [2:0] SLOT_COMPAT = 3'h5;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int SEL_W = 3;
	localparam logic [SEL_W-1:0] SEL_DEFAULT = 3'h0;
	localparam logic [31:0] GROUP_RESET = 32'h0000_0000;
	localparam logic [15:0] COMPAT_RESET = 16'h0000;
	localparam logic [15:0] UNLOCK_KEY = 16'hEAEF;
	localparam int KEY_W = 16;

	// Writable field bits per group, index 0 is group 6
	localparam logic [NUM_GROUPS-1:0][31:0] GROUP_MASK = {
		32'h071C_7FFF,
		32'h3FE0_703F,
		32'h3800_7FFF,
		32'h001F_FFFF,
		32'h3FFF_FFFF
	};
	localparam int GROUP_A_IDX = 4;
	localparam logic [31:0] CARD_MASK = 32'h071C_0000;

	// Synchroniser depth for the strap input
	localparam int SYNC_DEPTH = 3;
	localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

	typedef enum logic {STRAP_WAIT, STRAP_HELD} strap_state_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [2:0] sel_general_pin_4;
		logic [2:0] sel_general_pin_6;
		logic [2:0] sel_general_pin_7;
		logic [2:0] sel_general_pin_11;
		logic [2:0] sel_general_pin_12;
		logic [2:0] sel_general_pin_13;
		logic [2:0] sel_general_pin_14;
		logic [2:0] sel_general_pin_15;
		logic [2:0] sel_serial3_receive;
		logic [2:0] sel_serial3_transmit;
	} group6_s;

	typedef struct packed {
		logic [10:0] rsvd_hi;
		logic [2:0] sel_processor_io_2;
		logic [2:0] sel_processor_io_4;
		logic [2:0] sel_processor_io_5;
		logic [2:0] sel_general_pin_0;
		logic [2:0] sel_general_pin_1;
		logic [2:0] sel_general_pin_2;
		logic [2:0] sel_general_pin_3;
	} group7_s;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [2:0] sel_boot_mode_pin;
		logic [11:0] rsvd_mid;
		logic [2:0] sel_microwire_cs3;
		logic [2:0] sel_microwire_cs0;
		logic [2:0] sel_microwire_clock;
		logic [2:0] sel_microwire_data_out;
		logic [2:0] sel_microwire_data_in;
	} group8_s;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic [2:0] sel_serial3_clock_request;
		logic [2:0] sel_mserial1_data_out;
		logic [2:0] sel_serial1_transmit;
		logic [5:0] rsvd_mid;
		logic [2:0] sel_serial1_request_to_send;
		logic [5:0] rsvd_lo;
		logic [2:0] sel_buffered3_tx_clock;
		logic [2:0] sel_host_reset_out;
	} group9_s;

	typedef struct packed {
		logic [4:0] rsvd_hi;
		logic [2:0] sel_card_data_1;
		logic [2:0] rsvd_a;
		logic [2:0] sel_card_data_2;
		logic [2:0] rsvd_b;
		logic [2:0] sel_slow_clock_out;
		logic [2:0] sel_mserial1_data_in;
		logic [2:0] sel_mserial1_clock;
		logic [2:0] sel_mserial1_sync;
		logic [2:0] sel_serial_bit_clock;
	} groupa_s;

endpackage : pin_select_pkg

`default_nettype wire

// >>> hw/strap_sync.sv
`default_nettype none

module strap_sync
	import pin_select_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Pin side
	input wire logic pin_in,
	// Synchronised view
	output logic level,
	output logic settled
);

	typedef struct packed {
		logic [SYNC_DEPTH-1:0] chain;
	} sync_s;

	sync_s cur_r;
	sync_s cur_nxt;

	always_comb
	begin
		cur_nxt = cur_r;
		cur_nxt.chain = {cur_r.chain[SYNC_DEPTH-2:0], pin_in};
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			cur_r <= '0;
		else
			cur_r <= cur_nxt;
	end

	// Only the second and third stages are looked at
	assign level = cur_r.chain[2];
	assign settled = (cur_r.chain[1] == cur_r.chain[2]);

endmodule : strap_sync

`default_nettype wire

// >>> hw/pin_function_select_bank.sv
// Operation
// - Each selection field is RW, resets to 0 and, except the card data fields, is forced to 000 in compat.
// - Each field picks one I/O's function; code 000 is the default function.
// - Card data fields are forced only if static-valid was high at reset.
// - Group 6: general pins at 29-27 down to 8-6, serial 3 rx 5-3, tx 2-0.
// - Group 7: 31-21 reserved, processor I/O at 20-12, general 0-3 at 11-0.
// - Group 8: boot pin at 29-27, 26-15 reserved, microwire fields at 14-0.
// - Group 9: fields at 29-21, 14-12, 5-0; 20-15 and 11-6 reserved.
// - Group A: fields at 26-24, 20-18, 14-0; 31-27, 23-21, 17-15 reserved.
// - Compat mode ends only when the 16-bit unlock key is written.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none

module pin_function_select_bank
	import pin_select_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register bus
	input wire apb_req_s apb_req,
	output apb_rsp_s apb_rsp,
	// Strap pin
	input wire logic static_valid,
	// Pin mux selections
	output group6_s mux_group_6,
	output group7_s mux_group_7,
	output group8_s mux_group_8,
	output group9_s mux_group_9,
	output groupa_s mux_group_a,
	// Status
	output logic compat_active,
	output logic strap_latched
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_GROUPS-1:0][31:0] stored;
		logic [KEY_W-1:0] compat_key;
		logic [NUM_GROUPS-1:0][31:0] sel_out;
		logic [31:0] rdata;
		logic slverr;
		strap_state_e strap;
		logic [1:0] wait_cnt;
		logic strap_high;
		logic compat;
	} state_s;

	state_s cur_r;
	state_s cur_nxt;

	logic sv_level;
	logic sv_settled;
	logic [2:0] slot;
	logic setup_phase;
	logic access_phase;
	logic force_sel;
	logic [31:0] force_mask;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic [2:0] decode_slot(logic [ADDR_W-1:0] addr);
		logic [2:0] s;
		case (addr)
			ADDR_GROUP_6: s = 3'h0;
			ADDR_GROUP_7: s = 3'h1;
			ADDR_GROUP_8: s = 3'h2;
			ADDR_GROUP_9: s = 3'h3;
			ADDR_GROUP_A: s = 3'h4;
			ADDR_COMPAT: s = SLOT_COMPAT;
			default: s = SLOT_NONE;
		endcase
		return s;
	endfunction : decode_slot

	strap_sync u_strap_sync (
		.clock(clock),
		.arst_n(arst_n),
		.pin_in(static_valid),
		.level(sv_level),
		.settled(sv_settled)
	);

	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign access_phase = apb_req.psel && apb_req.penable;
	assign slot = decode_slot(apb_req.paddr);

	// Forcing holds until the strap is known and while compat mode lasts
	assign force_sel = cur_r.compat || (cur_r.strap == STRAP_WAIT);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		cur_nxt = cur_r;
		// Read data and error are prepared in the setup phase
		if (setup_phase)
		begin
			cur_nxt.slverr = (slot == SLOT_NONE);
			if (slot == SLOT_COMPAT)
				cur_nxt.rdata = {16'h0000, cur_r.compat_key};
			else if (slot < SLOT_COMPAT)
				cur_nxt.rdata = cur_r.stored[slot] & GROUP_MASK[slot];
			else
				cur_nxt.rdata = 32'h0000_0000;
		end
		// Writes land at the access edge; reserved bits are dropped
		if (access_phase && apb_req.pwrite)
		begin
			if (slot == SLOT_COMPAT)
				cur_nxt.compat_key = apb_req.pwdata[KEY_W-1:0];
			else if (slot < SLOT_COMPAT)
				cur_nxt.stored[slot] = apb_req.pwdata & GROUP_MASK[slot];
		end
		cur_nxt.compat = (cur_nxt.compat_key != UNLOCK_KEY);

		// Strap capture once the synchroniser has filled
		case (cur_r.strap)
			STRAP_WAIT:
			begin
				if (cur_r.wait_cnt != STRAP_WAIT_CYCLES)
					cur_nxt.wait_cnt = cur_r.wait_cnt + 2'h1;
				else if (sv_settled)
				begin
					cur_nxt.strap_high = sv_level;
					cur_nxt.strap = STRAP_HELD;
				end
			end
			STRAP_HELD:
				cur_nxt.strap = STRAP_HELD;
			default:
				cur_nxt.strap = STRAP_WAIT;
		endcase
	end

	// ----------------------------------------------------------------
	// Selections driven to the pin mux
	// ----------------------------------------------------------------
	always_comb
	begin
		force_mask = GROUP_MASK[GROUP_A_IDX];
		if (cur_r.strap == STRAP_HELD && !cur_r.strap_high)
			force_mask = GROUP_MASK[GROUP_A_IDX] & ~CARD_MASK;
	end

	state_s mux_nxt;

	always_comb
	begin
		mux_nxt = cur_nxt;
		for (int g = 0; g < NUM_GROUPS; g++)
		begin
			if (!force_sel)
				mux_nxt.sel_out[g] = cur_r.stored[g] & GROUP_MASK[g];
			else if (g == GROUP_A_IDX)
				mux_nxt.sel_out[g] = cur_r.stored[g] & GROUP_MASK[g] & ~force_mask;
			else
				mux_nxt.sel_out[g] = GROUP_RESET;
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cur_r.stored <= '0;
			cur_r.compat_key <= COMPAT_RESET;
			cur_r.sel_out <= '0;
			cur_r.rdata <= 32'h0000_0000;
			cur_r.slverr <= 1'b0;
			cur_r.strap <= STRAP_WAIT;
			cur_r.wait_cnt <= 2'h0;
			cur_r.strap_high <= 1'b0;
			cur_r.compat <= 1'b1;
		end
		else
			cur_r <= mux_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign apb_rsp.prdata = cur_r.rdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = access_phase && cur_r.slverr;
	assign mux_group_6 = group6_s'(cur_r.sel_out[0]);
	assign mux_group_7 = group7_s'(cur_r.sel_out[1]);
	assign mux_group_8 = group8_s'(cur_r.sel_out[2]);
	assign mux_group_9 = group9_s'(cur_r.sel_out[3]);
	assign mux_group_a = groupa_s'(cur_r.sel_out[GROUP_A_IDX]);
	assign compat_active = cur_r.compat;
	assign strap_latched = cur_r.strap_high;

endmodule : pin_function_select_bank

`default_nettype wire

// >>> test/pin_function_select_bank_properties.sv
`default_nettype none

module pin_select_checker
	import pin_select_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register bus
	input wire apb_req_s apb_req,
	input wire apb_rsp_s apb_rsp,
	// Strap and pin mux
	input wire logic static_valid,
	input wire group6_s mux_group_6,
	input wire group7_s mux_group_7,
	input wire group8_s mux_group_8,
	input wire group9_s mux_group_9,
	input wire groupa_s mux_group_a,
	input wire logic compat_active,
	input wire logic strap_latched
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	wire logic acc = apb_req.psel && apb_req.penable;
	wire logic wr6 = acc && apb_req.pwrite && apb_req.paddr == ADDR_GROUP_6;
	wire logic wrk = acc && apb_req.pwrite && apb_req.paddr == ADDR_COMPAT;
	wire logic key_ok = apb_req.pwdata[15:0] == UNLOCK_KEY;

	a_compat_forced: assert property (compat_active && $past(compat_active)
		|-> {mux_group_6, mux_group_7, mux_group_8, mux_group_9} == '0)
		else $error("selection not forced in compatibility mode");
	a_group_a_forced: assert property (compat_active && $past(compat_active)
		|-> (mux_group_a & ~CARD_MASK) == '0)
		else $error("group a not forced in compatibility mode");
	a_card_forced: assert property (compat_active && $past(compat_active)
		&& strap_latched |-> (mux_group_a & CARD_MASK) == '0)
		else $error("card data not forced with strap high");
	a_reserved_zero: assert property ((mux_group_8 & ~GROUP_MASK[2]) == '0
		&& (mux_group_9 & ~GROUP_MASK[3]) == '0)
		else $error("reserved selection bits driven");
	a_write_effect: assert property ((wr6 && !compat_active) ##1
		(!wr6 && !compat_active) |-> ##1 (compat_active
		|| mux_group_6 == ($past(apb_req.pwdata, 2) & GROUP_MASK[0])))
		else $error("native write not passed to pin mux");
	a_unlock_leaves: assert property (wrk && key_ok
		|-> ##[1:2] !compat_active)
		else $error("unlock key did not leave compatibility mode");
	a_wrong_key_locks: assert property (wrk && !key_ok
		|-> ##[1:2] compat_active)
		else $error("wrong key left compatibility mode");
	a_read_reserved: assert property (acc && !apb_req.pwrite
		&& apb_req.paddr == ADDR_GROUP_7 |-> (apb_rsp.prdata & ~GROUP_MASK[1]) == '0)
		else $error("reserved bits read back nonzero");
	a_strap_capture: assert property ($rose(strap_latched)
		|-> $past(static_valid, 4))
		else $error("strap latched without static-valid high");
endmodule : pin_select_checker

bind pin_function_select_bank pin_select_checker i_checker (.clock, .arst_n,
	.apb_req, .apb_rsp, .static_valid, .mux_group_6, .mux_group_7,
	.mux_group_8, .mux_group_9, .mux_group_a, .compat_active, .strap_latched);

`default_nettype wire

// >>> test/pin_function_select_bank_tb.sv
`default_nettype none

module pin_function_select_bank_tb
	import pin_select_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] PAT = 32'h5A5A_A5A5;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic static_valid = 1'b1;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	group6_s g6;
	group7_s g7;
	group8_s g8;
	group9_s g9;
	groupa_s ga;
	logic compat_active;
	logic strap_latched;
	logic [31:0] mux_v [5];
	int n_mismatch = 0;
	int samples_checked = 0;

	always #5 clock = ~clock;
	assign mux_v[0] = g6;
	assign mux_v[1] = g7;
	assign mux_v[2] = g8;
	assign mux_v[3] = g9;
	assign mux_v[4] = ga;

	pin_function_select_bank i_dut (.clock, .arst_n, .apb_req(req),
		.apb_rsp(rsp), .static_valid, .mux_group_6(g6), .mux_group_7(g7),
		.mux_group_8(g8), .mux_group_9(g9), .mux_group_a(ga),
		.compat_active, .strap_latched);

	// ------------------------------------------------------------
	// Bus and check helpers
	// ------------------------------------------------------------
	task automatic close_out();
		$display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 50);
		if (rsp.pready !== 1'b1)
		begin
			n_mismatch++;
			close_out();
		end
		else
		begin
			q = rsp.prdata;
			e = rsp.pslverr;
			req <= '0;
		end
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk(32'(e), 32'(xe));
	endtask : rd

	function automatic logic [11:0] ga_of(input int i);
		return ADDR_GROUP_6 + 12'(4 * i);
	endfunction : ga_of

	task automatic do_reset(input logic sv);
		arst_n <= 1'b0;
		static_valid <= sv;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (8) @(posedge clock);
		chk(32'(strap_latched), 32'(sv));
	endtask : do_reset

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_program();
		for (int i = 0; i < NUM_GROUPS; i++)
		begin
			rd(ga_of(i), 32'h0, 1'b0);
			wr(ga_of(i), GROUP_MASK[i] & PAT);
		end
		for (int i = 0; i < NUM_GROUPS; i++)
		begin
			rd(ga_of(i), GROUP_MASK[i] & PAT, 1'b0);
			chk(mux_v[i], 32'h0);
		end
		chk(32'(compat_active), 32'h1);
	endtask : s_program

	task automatic s_unlock_relock();
		wr(ADDR_COMPAT, {16'h0, UNLOCK_KEY});
		repeat (3) @(posedge clock);
		chk(32'(compat_active), 32'h0);
		for (int i = 0; i < NUM_GROUPS; i++)
			chk(mux_v[i], GROUP_MASK[i] & PAT);
		wr(ADDR_GROUP_6, GROUP_MASK[0] & ~PAT);
		repeat (3) @(posedge clock);
		chk(mux_v[0], GROUP_MASK[0] & ~PAT);
		wr(ADDR_COMPAT, 32'h0);
		repeat (3) @(posedge clock);
		for (int i = 0; i < NUM_GROUPS; i++)
			chk(mux_v[i], 32'h0);
		rd(ADDR_GROUP_6, GROUP_MASK[0] & ~PAT, 1'b0);
		rd(12'h010, 32'h0, 1'b1);
		rd(12'h019, 32'h0, 1'b1);
	endtask : s_unlock_relock

	task automatic s_strap(input logic sv);
		do_reset(sv);
		wr(ADDR_GROUP_A, GROUP_MASK[4] & PAT);
		repeat (3) @(posedge clock);
		chk(mux_v[4], sv ? 32'h0 : GROUP_MASK[4] & PAT & CARD_MASK);
	endtask : s_strap

	initial
	begin
		do_reset(1'b1);
		s_program();
		s_unlock_relock();
		s_strap(1'b0);
		s_strap(1'b1);
		close_out();
	end
endmodule : pin_function_select_bank_tb

`default_nettype wire
